/* hw/ipb_bank.sv */
// ============================================================================
// ipb_bank: interrupt priority configuration bank behind AXI4-Lite
// ============================================================================
// holds eight 16-bit priority words and presents one decoded level per source
// assumes aclk at 50 MHz, synchronous aresetn, one master, can_present static
module ipb_bank
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [ipb_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [ipb_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ipb_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [ipb_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // device variant and source flags
    input wire logic can_present,
    input wire logic [ipb_pkg::SRC_COUNT-1:0] src_flag,
    // toward the arbiter
    output ipb_pkg::ipb_src_prio_t [ipb_pkg::SRC_COUNT-1:0] src_prio,
    output logic [ipb_pkg::SRC_COUNT-1:0] src_request
);
    import ipb_pkg::*;

    // ========================================================================
    // declarations
    // ========================================================================
    logic [15:0] bank_reg [0:7];
    logic [15:0] bank_next [0:7];
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg;
    logic arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic aw_got_reg, aw_got_next;
    logic w_got_reg, w_got_next;
    logic [31:0] awaddr_reg;
    logic [15:0] wdata_reg;
    logic [1:0] wstrb_reg;
    logic aw_take, w_take, wr_fire, ar_take;
    ipb_dec_t wr_dec, rd_dec;
    logic [31:0] rd_word;
    ipb_src_prio_t [SRC_COUNT-1:0] prio_comb;
    ipb_src_prio_t [SRC_COUNT-1:0] src_prio_reg;
    logic [SRC_COUNT-1:0] src_request_reg;

    // ========================================================================
    // write channel handshakes
    // ========================================================================
    // address and data are caught independently, so either may come first
    assign aw_take = s_axi_awvalid && awready_reg;
    assign w_take = s_axi_wvalid && wready_reg;
    // commit only once both halves are held; one write in flight at a time
    assign wr_fire = aw_got_reg && w_got_reg;
    assign aw_got_next = (aw_got_reg && !wr_fire) || aw_take;
    assign w_got_next = (w_got_reg && !wr_fire) || w_take;
    assign bvalid_next = wr_fire || (bvalid_reg && !s_axi_bready);
    // ready stays low until the response has been accepted
    assign awready_next = !aw_got_next && !bvalid_next;
    assign wready_next = !w_got_next && !bvalid_next;
    assign wr_dec = ipb_decode(awaddr_reg);

    // write handshake state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
        end
        else
        begin
            aw_got_reg <= aw_got_next;
            w_got_reg <= w_got_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
        end
    end

    // captured write payload and response code
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awaddr_reg <= 32'h00000000;
            wdata_reg <= 16'h0000;
            wstrb_reg <= 2'h0;
            bresp_reg <= RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_take)
            begin
                wdata_reg <= s_axi_wdata[15:0];
                wstrb_reg <= s_axi_wstrb[1:0];
            end
            if (wr_fire)
            begin
                bresp_reg <= wr_dec.hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ========================================================================
    // priority word storage
    // ========================================================================
    // byte lanes 2 and 3 carry no bits; the mask drops unimplemented ones
    genvar r;
    generate
        for (r = 0; r < BANK_COUNT; r++)
        begin : g_bank
            logic [15:0] merged;
            logic sel;
            assign merged[7:0] = wstrb_reg[0] ? wdata_reg[7:0] : bank_reg[r][7:0];
            assign merged[15:8] = wstrb_reg[1] ? wdata_reg[15:8] : bank_reg[r][15:8];
            assign bank_next[r] = merged & BANK_MASK[r];
            assign sel = wr_fire && wr_dec.hit && (wr_dec.idx == 3'(r));

            // one word; power-on pattern 100 in every field
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    bank_reg[r] <= BANK_RESET[r];
                end
                else if (sel)
                begin
                    bank_reg[r] <= bank_next[r];
                end
            end
        end
    endgenerate

    // ========================================================================
    // read channel
    // ========================================================================
    // address taken only while no read data is waiting
    assign ar_take = s_axi_arvalid && arready_reg;
    assign rvalid_next = ar_take || (rvalid_reg && !s_axi_rready);
    assign arready_next = !rvalid_next;
    assign rd_dec = ipb_decode(s_axi_araddr);
    // upper half and unmapped words read as zero
    assign rd_word = rd_dec.hit ? {16'h0000, bank_reg[rd_dec.idx]} : 32'h00000000;

    // read handshake state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // read data held until rready
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rdata_reg <= 32'h00000000;
            rresp_reg <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            rdata_reg <= rd_word;
            rresp_reg <= rd_dec.hit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // ========================================================================
    // per-source field decode
    // ========================================================================
    // placement tables give each source its word and bit position
    genvar s;
    generate
        for (s = 0; s < SRC_COUNT; s++)
        begin : g_src
            logic [2:0] code;
            logic allowed;
            // field slice
            assign code = bank_reg[SRC_REG[s]][SRC_LSB[s] +: FIELD_W];
            // a variant without the can controller forces that source off
            assign allowed = (s == CAN_TRANSMIT_REQUEST_PRIORITY) ? can_present : 1'b1;
            ipb_field_decode u_decode
            (
                .code(code),
                .allowed(allowed),
                .prio(prio_comb[s])
            );
        end
    endgenerate

    // registered outputs toward the arbiter, one cycle behind the words
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            src_prio_reg <= '0;
            src_request_reg <= '0;
        end
        else
        begin
            src_prio_reg <= prio_comb;
            // a disabled source never raises a request, whatever its flag
            src_request_reg <= src_flag & get_enables(prio_comb);
        end
    end

    // gathers the enable bit of every source
    function automatic logic [SRC_COUNT-1:0] get_enables(
        input ipb_src_prio_t [SRC_COUNT-1:0] p);
        logic [SRC_COUNT-1:0] e;
        e = '0;
        for (int i = 0; i < SRC_COUNT; i++)
        begin
            e[i] = p[i].enable;
        end
        return e;
    endfunction

    // ========================================================================
    // output drive
    // ========================================================================
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign src_prio = src_prio_reg;
    assign src_request = src_request_reg;

endmodule // ipb_bank

/* hw/ipb_field_decode.sv */
// ============================================================================
// ipb_field_decode: turns one 3-bit priority code into a level and enable
// ============================================================================
// assumes the caller registers the result; purely combinational
module ipb_field_decode
(
    // field in
    input wire logic [2:0] code,
    input wire logic allowed,
    // decoded priority out
    output ipb_pkg::ipb_src_prio_t prio
);
    import ipb_pkg::*;

    // code equals level; zero or a missing peripheral disables the source
    logic live;
    assign live = allowed && (code != PRIO_DISABLED);
    assign prio.enable = live;
    // 111 gives 7, 001 gives 1, 010..110 give 2..6
    assign prio.level = live ? code : PRIO_DISABLED;

endmodule // ipb_field_decode

/* hw/ipb_pkg.sv */
// ============================================================================
// ipb_pkg: shared constants and types for the interrupt priority bank
// ============================================================================
// assumes a 32-bit AXI4-Lite register bus and one 50 MHz system clock
package ipb_pkg;

    // ========================================================================
    // bus constants
    // ========================================================================
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 32;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ========================================================================
    // register offsets (byte addresses, one aligned word each)
    // ========================================================================
    localparam logic [31:0] OFS_PRIO_CAPTURE_DMA_A = 32'h00000000;
    localparam logic [31:0] OFS_PRIO_TWOWIRE_SECOND = 32'h00000004;
    localparam logic [31:0] OFS_PRIO_EXTERNAL_PINS_B = 32'h00000008;
    localparam logic [31:0] OFS_PRIO_ENCODER_PWM_EVENT = 32'h0000000C;
    localparam logic [31:0] OFS_PRIO_SERIAL_ERRORS = 32'h00000010;
    localparam logic [31:0] OFS_PRIO_CAN_TRANSMIT = 32'h00000014;
    localparam logic [31:0] OFS_PRIO_ENCODER2_PWM_SECONDARY = 32'h00000018;
    localparam logic [31:0] OFS_PRIO_CONVERTER_PAIRS_HI = 32'h0000001C;
    localparam int unsigned BANK_COUNT = 8;
    localparam int unsigned REG_W = 16;

    // implemented-bit masks and power-on values, by register index
    localparam logic [15:0] BANK_MASK [0:7] = '{
        16'h0777, 16'h0770, 16'h0770, 16'h0770,
        16'h0770, 16'h0700, 16'h7070, 16'h7770};
    localparam logic [15:0] BANK_RESET [0:7] = '{
        16'h0444, 16'h0440, 16'h0440, 16'h0440,
        16'h0440, 16'h0400, 16'h4040, 16'h4440};

    // ========================================================================
    // priority field codes
    // ========================================================================
    localparam int unsigned FIELD_W = 3;
    localparam logic [2:0] PRIO_DISABLED = 3'h0;
    localparam logic [2:0] PRIO_LOWEST = 3'h1;
    localparam logic [2:0] PRIO_HIGHEST = 3'h7;
    localparam logic [2:0] PRIO_RESET = 3'h4;

    // ========================================================================
    // source indices and field placement
    // ========================================================================
    localparam int unsigned SRC_COUNT = 17;
    localparam int unsigned CAPTURE4_PRIORITY = 0;
    localparam int unsigned CAPTURE3_PRIORITY = 1;
    localparam int unsigned DMA_CHANNEL3_DONE_PRIORITY = 2;
    localparam int unsigned TWOWIRE2_MASTER_PRIORITY = 3;
    localparam int unsigned TWOWIRE2_SLAVE_PRIORITY = 4;
    localparam int unsigned EXT_PIN4_PRIORITY = 5;
    localparam int unsigned EXT_PIN3_PRIORITY = 6;
    localparam int unsigned ENCODER1_PRIORITY = 7;
    localparam int unsigned PWM_EVENT_MATCH_PRIORITY = 8;
    localparam int unsigned SERIAL2_ERROR_PRIORITY = 9;
    localparam int unsigned SERIAL1_ERROR_PRIORITY = 10;
    localparam int unsigned CAN_TRANSMIT_REQUEST_PRIORITY = 11;
    localparam int unsigned ENCODER2_PRIORITY = 12;
    localparam int unsigned PWM_SECONDARY_MATCH_PRIORITY = 13;
    localparam int unsigned CONVERTER_PAIR10_PRIORITY = 14;
    localparam int unsigned CONVERTER_PAIR9_PRIORITY = 15;
    localparam int unsigned CONVERTER_PAIR8_PRIORITY = 16;

    // register index and field lsb of each source, by source index
    localparam int unsigned SRC_REG [0:16] = '{
        0, 0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 5, 6, 6, 7, 7, 7};
    localparam int unsigned SRC_LSB [0:16] = '{
        8, 4, 0, 8, 4, 8, 4, 8, 4, 8, 4, 8, 12, 4, 12, 8, 4};

    // ========================================================================
    // types
    // ========================================================================
    typedef struct packed {
        logic enable;
        logic [2:0] level;
    } ipb_src_prio_t;

    typedef struct packed {
        logic hit;
        logic [2:0] idx;
    } ipb_dec_t;

    // address decode shared by the read and write paths
    function automatic ipb_dec_t ipb_decode(input logic [31:0] addr);
        ipb_dec_t d;
        d.hit = (addr[31:5] == 27'h0000000);
        d.idx = addr[4:2];
        return d;
    endfunction

endpackage

/* testbench/ipb_bank_checker.sv */
// ============================================================================
// ipb_bank_checker: bus and priority-output timing checks on ipb_bank
// assumes ipb_pkg compiled first; bound to every ipb_bank by name
module ipb_bank_checker
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [ipb_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // sources
    input wire logic can_present,
    input wire logic [ipb_pkg::SRC_COUNT-1:0] src_flag,
    input ipb_pkg::ipb_src_prio_t [ipb_pkg::SRC_COUNT-1:0] src_prio,
    input wire logic [ipb_pkg::SRC_COUNT-1:0] src_request
);
    timeunit 1ns;
    timeprecision 1ps;
    import ipb_pkg::*;
    logic [SRC_COUNT-1:0] en_vec;
    logic [SRC_COUNT-1:0] lvl_nz;
    // flatten the struct array so enables compare as one vector
    always_comb
    begin
        for (int i = 0; i < SRC_COUNT; i++)
        begin
            en_vec[i] = src_prio[i].enable;
            lvl_nz[i] = |src_prio[i].level;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ========================================================================
    // assertions
    // ========================================================================
    b_after_both_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
    r_after_ar_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read answer late");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while data pending");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data not held");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response not held");
    rdata_unimpl_a: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'hFFFF8888) == 32'h0)
        else $error("unassigned bit read as one");
    req_follow_a: assert property ($past(aresetn) && $stable(en_vec) |->
        src_request == ($past(src_flag) & en_vec)) else $error("request not flag and enable");
    en_level_a: assert property (en_vec == lvl_nz)
        else $error("enable and level disagree");
    can_off_a: assert property (!$past(can_present) && !can_present |->
        !src_prio[CAN_TRANSMIT_REQUEST_PRIORITY].enable) else $error("absent can enabled");
    reset_prio_a: assert property ($rose(aresetn) |=> src_prio[0] == {1'b1, PRIO_RESET}
        && src_prio[16] == {1'b1, PRIO_RESET}) else $error("priority not four after reset");
endmodule // ipb_bank_checker

bind ipb_bank ipb_bank_checker chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .can_present(can_present), .src_flag(src_flag),
    .src_prio(src_prio), .src_request(src_request));

/* testbench/ipb_bank_tb.sv */
// ============================================================================
// ipb_bank_tb: self-checking bench for the priority bank
// assumes ipb_pkg, ipb_bank and the bound checker are compiled first
module ipb_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ipb_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, can_present = 1'b1;
    logic [SRC_COUNT-1:0] src_flag = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    ipb_src_prio_t [SRC_COUNT-1:0] src_prio;
    logic [SRC_COUNT-1:0] src_request;
    int errors = 0, cmp_count = 0;
    logic [31:0] seed = 32'h00000B41;
    logic [15:0] model [0:7];
    // own copy of field placement, so a wrong package table shows up
    localparam int RT [0:16] = '{0, 0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 5, 6, 6, 7, 7, 7};
    localparam int LT [0:16] = '{8, 4, 0, 8, 4, 8, 4, 8, 4, 8, 4, 8, 12, 4, 12, 8, 4};
    localparam logic [15:0] MK [0:7] = '{16'h0777, 16'h0770, 16'h0770, 16'h0770,
        16'h0770, 16'h0700, 16'h7070, 16'h7770};

    // design under test; protection and strobes are fixed
    ipb_bank dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .can_present(can_present), .src_flag(src_flag),
        .src_prio(src_prio), .src_request(src_request));

    // 50 MHz clock
    initial
    begin
        forever #10 aclk = ~aclk;
    end

    // ========================================================================
    // helpers
    // ========================================================================
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            errors++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic give_up();
        errors++;
        $display("FAIL bus answer expected within 100 cycles seen none");
        final_report();
    endtask
    // each task waits one edge first, so no signal is driven twice in a step
    // a late ready keeps the answer waiting, so its hold is exercised
    task automatic bus_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        int lag;
        lag = int'(seed[3:2]);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
            if (n == lag) s_axi_bready <= 1'b1;
        end
        if (n == 100) give_up();
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic bus_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        int lag;
        lag = int'(seed[3:2]);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            if (n == lag) s_axi_rready <= 1'b1;
        end
        if (n == 100) give_up();
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // word index 8 lands outside the bank
    task automatic put(input int i, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        bus_write(32'(i) << 2, d, r);
        chk("write response", {30'h0, er}, {30'h0, r});
        if (i < 8) model[i] = d[15:0] & MK[i];
    endtask
    task automatic get(input int i, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        bus_read(32'(i) << 2, d, r);
        chk("read response", {30'h0, er}, {30'h0, r});
        chk("read data", (i < 8) ? {16'h0, model[i]} : 32'h0, d);
    endtask
    function automatic logic [3:0] exp_prio(input int s);
        logic [2:0] c;
        c = model[RT[s]][LT[s] +: 3];
        if (s == CAN_TRANSMIT_REQUEST_PRIORITY && !can_present) c = 3'h0;
        return {c != 3'h0, c};
    endfunction
    task automatic chk_prio();
        logic [3:0] e;
        repeat (3) @(posedge aclk);
        for (int s = 0; s < SRC_COUNT; s++)
            chk("source priority", {28'h0, exp_prio(s)}, 32'(src_prio[s]));
        // flags of word 0 and the can source always pending, so a disabled code shows
        src_flag <= seed[16:0] | 17'h00807;
        repeat (3) @(posedge aclk);
        for (int s = 0; s < SRC_COUNT; s++)
        begin
            e = exp_prio(s);
            chk("source request", {31'h0, src_flag[s] & e[3]}, {31'h0, src_request[s]});
        end
    endtask

    // ========================================================================
    // main sequence
    // ========================================================================
    initial
    begin
        for (int i = 0; i < 8; i++) model[i] = MK[i] & 16'h4444;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 8; i++) get(i, RESP_OKAY);
        chk_prio();
        $display("test reset values done");
        for (int k = 0; k < 48; k++)
        begin
            seed = lfsr(seed);
            put(k % 8, seed, RESP_OKAY);
            get(k % 8, RESP_OKAY);
            if (k % 8 == 7) chk_prio();
        end
        $display("test random words done");
        for (int c = 0; c < 8; c++)
        begin
            put(0, 32'(c * 16'h0111), RESP_OKAY);
            chk_prio();
        end
        $display("test codes done");
        can_present <= 1'b0;
        put(5, 32'h0000FFFF, RESP_OKAY);
        get(5, RESP_OKAY);
        chk_prio();
        can_present <= 1'b1;
        chk_prio();
        $display("test can variant done");
        put(8, 32'h0000FFFF, RESP_SLVERR);
        get(8, RESP_SLVERR);
        get(0, RESP_OKAY);
        $display("test unmapped done");
        // second reset in mid-run after the bank was rewritten
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 8; i++) model[i] = MK[i] & 16'h4444;
        for (int i = 0; i < 8; i++) get(i, RESP_OKAY);
        chk_prio();
        $display("test second reset done");
        final_report();
    end
endmodule // ipb_bank_tb
